// *** hw/sis_pkg.sv ***
// package: register map, field layout and mode codes of the status/interrupt block
package sis_pkg;
  // register offsets on the serial register port
  localparam logic [7:0] SIS_ADDR_FIFO_STATUS = 8'h00;
  localparam logic [7:0] SIS_ADDR_XYZ_FIRST   = 8'h01;
  localparam logic [7:0] SIS_ADDR_XYZ_LAST    = 8'h06;
  localparam logic [7:0] SIS_ADDR_TRIG_SEL    = 8'h0a;
  localparam logic [7:0] SIS_ADDR_SYS_MODE    = 8'h0b;
  localparam logic [7:0] SIS_ADDR_INT_SRC     = 8'h0c;
  localparam logic [7:0] SIS_ADDR_IDENTITY    = 8'h0d;
  localparam logic [7:0] SIS_ADDR_ORIENT_STS  = 8'h10;
  localparam logic [7:0] SIS_ADDR_FALL_SRC    = 8'h16;
  localparam logic [7:0] SIS_ADDR_TRANSIENT_SOURCE_REGISTER   = 8'h1e;
  localparam logic [7:0] SIS_ADDR_TAP_SRC     = 8'h22;
  // trigger select field positions
  localparam int SIS_TRIGGER_ON_TRANSIENT = 5;
  localparam int SIS_TRIG_ORIENT = 4;
  localparam int SIS_TRIG_TAP = 3;
  localparam int SIS_TRIG_FALL = 2;
  localparam logic [7:0] SIS_TRIG_MASK  = 8'h3c;
  localparam logic [7:0] SIS_TRIG_RESET = 8'h00;
  // interrupt source field positions
  localparam int SIS_AUTOSLEEP_EVENT_FLAG  = 7;
  localparam int SIS_FIFO_EVENT_FLAG  = 6;
  localparam int SIS_TRANSIENT_EVENT_FLAG = 5;
  localparam int SIS_SRC_ORIENT = 4;
  localparam int SIS_SRC_TAP   = 3;
  localparam int SIS_SRC_FALL  = 2;
  localparam int SIS_NEW_SAMPLE_EVENT_FLAG  = 0;
  // system mode register layout
  localparam int SIS_GERR_BIT = 7;
  localparam int SIS_ELAPSED_W = 5;
  localparam logic [4:0] SIS_ELAPSED_RESET = 5'h00;
  localparam logic [7:0] SIS_FIFO_FULL = 8'h20;
  // system mode encodings
  typedef enum logic [1:0] {
    SIS_MODE_STANDBY = 2'h0,
    SIS_MODE_WAKE    = 2'h1,
    SIS_MODE_SLEEP   = 2'h2
  } sis_mode_t;
  // raw event levels from the detection functions
  typedef struct packed {
    logic fifo_overflow;
    logic transient_active;
    logic orientation_changed;
    logic tap_active;
    logic fall_motion_active;
    logic xyz_new_data;
    logic xyz_overwrite;
  } sis_events_t;
  // per-function interrupt enables
  typedef struct packed {
    logic aslp;
    logic fifo;
    logic transient;
    logic orientation;
    logic tap;
    logic fall_motion;
    logic drdy;
  } sis_enables_t;
endpackage

// *** hw/sis_top.sv ***
// top: interrupt source, system mode, trigger select and identity registers
`timescale 1ns/1ps
module sis_top
  import sis_pkg::*;
#(
  parameter logic [7:0] PART_ID     = 8'h5c, // arbitrary neutral value
  parameter int         LIMIT_WIDTH = 8
) (
  input  wire logic                   mclk,
  input  wire logic                   rstn,
  input  wire logic                   clk_en,
  // register port from the serial front end (same clock domain)
  input  wire logic [7:0]             reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_rd_done,
  output logic      [7:0]             reg_rdata,
  // device state
  input  wire logic                   sample_tick,
  input  wire logic                   active_req,
  input  wire logic                   sleep_en,
  input  wire logic [LIMIT_WIDTH-1:0] sleep_inactivity_limit,
  input  wire sis_enables_t           int_enable,
  input  wire sis_enables_t           wake_select,
  input  wire sis_events_t            events,
  input  wire logic [5:0]             fifo_sample_count,
  input  wire logic [5:0]             fifo_watermark_level,
  input  wire logic                   gate_error_detect,
  output logic [3:0]                  fifo_trigger_enable,
  output sis_mode_t                   system_mode,
  output logic [7:0]                  interrupt_source_flags
);

  // ==========================================================================
  // state
  // ==========================================================================
  logic [7:0]             fifo_trigger_select;
  sis_mode_t              mode;
  logic                   fifo_gate_error;
  logic [4:0]             gate_error_elapsed;
  logic [7:0]             src_flags;
  logic [6:0]             level_q;
  logic [LIMIT_WIDTH-1:0] idle_count;
  logic [7:0]             rd_addr_q;

  // ==========================================================================
  // event levels and edges
  // ==========================================================================
  // watermark 0 disables the watermark event
  wire wmrk_hit = (fifo_watermark_level != 6'h00) &&
                  (fifo_sample_count == fifo_watermark_level);
  wire lvl_fifo  = int_enable.fifo && (events.fifo_overflow || wmrk_hit);
  wire lvl_trans = int_enable.transient && events.transient_active;
  wire lvl_orient = int_enable.orientation && events.orientation_changed;
  wire lvl_tap   = int_enable.tap && events.tap_active;
  wire lvl_fall  = int_enable.fall_motion && events.fall_motion_active;
  wire lvl_drdy  = int_enable.drdy &&
                   (events.xyz_new_data || events.xyz_overwrite);
  wire [6:0] level_now = {1'b0, lvl_fifo, lvl_trans, lvl_orient, lvl_tap, lvl_fall,
                          lvl_drdy};
  wire [6:0] rise = level_now & ~level_q;

  // wake-capable events for the autosleep machine
  wire [6:0] wake_mask = {1'b0, wake_select.fifo, wake_select.transient,
                          wake_select.orientation, wake_select.tap,
                          wake_select.fall_motion, wake_select.drdy};
  wire any_wake_event = |(rise & wake_mask);
  wire any_event      = |rise[6:1];

  // ==========================================================================
  // autosleep mode machine
  // ==========================================================================
  wire idle_expired = sample_tick && (idle_count == sleep_inactivity_limit);
  sis_mode_t next_mode;
  logic      mode_evt;
  always_comb begin
    next_mode = mode;
    mode_evt  = 1'b0;
    case (mode)
      SIS_MODE_STANDBY: begin
        if (active_req) next_mode = SIS_MODE_WAKE;
      end
      SIS_MODE_WAKE: begin
        if (!active_req) next_mode = SIS_MODE_STANDBY;
        else if (sleep_en && !any_event && idle_expired) begin
          next_mode = SIS_MODE_SLEEP;
          mode_evt  = 1'b1;
        end
      end
      SIS_MODE_SLEEP: begin
        if (!active_req) next_mode = SIS_MODE_STANDBY;
        else if (any_wake_event || !sleep_en) begin
          next_mode = SIS_MODE_WAKE;
          mode_evt  = any_wake_event;
        end
      end
      default: next_mode = SIS_MODE_STANDBY;
    endcase
  end

  // mode register and inactivity counter; any enabled event except data ready restarts the idle window
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode       <= SIS_MODE_STANDBY;
      idle_count <= '0;
    end else if (clk_en) begin
      mode <= next_mode;
      if (mode != SIS_MODE_WAKE || any_event || idle_expired) idle_count <= '0;
      else if (sample_tick) idle_count <= idle_count + 1'b1;
    end
  end

  // ==========================================================================
  // register read path
  // ==========================================================================
  wire [7:0] sysmode_byte = {fifo_gate_error, gate_error_elapsed, mode};
  wire [7:0] read_mux =
    (reg_addr == SIS_ADDR_TRIG_SEL)  ? (fifo_trigger_select & SIS_TRIG_MASK) :
    (reg_addr == SIS_ADDR_SYS_MODE)  ? sysmode_byte :
    (reg_addr == SIS_ADDR_INT_SRC)   ? src_flags :
    (reg_addr == SIS_ADDR_IDENTITY)  ? PART_ID :
    8'h00;

  // address held from the read request until the byte is handed over
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
      rd_addr_q <= 8'h00;
    end else if (clk_en && reg_rd) begin
      reg_rdata <= read_mux;
      rd_addr_q <= reg_addr;
    end
  end

  // ==========================================================================
  // read-to-clear decode (acts on rd_done only)
  // ==========================================================================
  wire in_xyz = (rd_addr_q >= SIS_ADDR_XYZ_FIRST) && (rd_addr_q <= SIS_ADDR_XYZ_LAST);
  wire clr_aslp  = reg_rd_done && (rd_addr_q == SIS_ADDR_SYS_MODE);
  wire clr_fifo  = reg_rd_done && (rd_addr_q == SIS_ADDR_FIFO_STATUS);
  wire clr_trans = reg_rd_done && (rd_addr_q == SIS_ADDR_TRANSIENT_SOURCE_REGISTER);
  wire clr_orient = reg_rd_done && (rd_addr_q == SIS_ADDR_ORIENT_STS);
  wire clr_tap   = reg_rd_done && (rd_addr_q == SIS_ADDR_TAP_SRC);
  wire clr_fall  = reg_rd_done && (rd_addr_q == SIS_ADDR_FALL_SRC);
  // 0x00 is not in the xyz range, so a status read leaves the flag alone
  wire clr_drdy  = reg_rd_done && in_xyz;

  wire [7:0] set_vec = {mode_evt, rise[5:1], 1'b0, rise[0]};
  wire [7:0] clr_vec = {clr_aslp, clr_fifo, clr_trans, clr_orient, clr_tap, clr_fall,
                        1'b0, clr_drdy};
  // set wins over clear so an edge in the clearing cycle is kept
  wire [7:0] next_src_flags = set_vec | (src_flags & ~clr_vec);

  // ==========================================================================
  // source flags and edge history
  // ==========================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      src_flags <= 8'h00;
      level_q   <= 7'h00;
    end else if (clk_en) begin
      src_flags <= next_src_flags;
      level_q   <= level_now;
    end
  end

  // ==========================================================================
  // trigger select register
  // ==========================================================================
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) fifo_trigger_select <= SIS_TRIG_RESET;
    else if (clk_en && reg_wr && reg_addr == SIS_ADDR_TRIG_SEL)
      fifo_trigger_select <= reg_wdata & SIS_TRIG_MASK;
  end

  // ==========================================================================
  // fifo gate error and elapsed counter
  // ==========================================================================
  wire fifo_empty = (fifo_sample_count == 6'h00);
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fifo_gate_error    <= 1'b0;
      gate_error_elapsed <= SIS_ELAPSED_RESET;
    end else if (clk_en) begin
      if (gate_error_detect) fifo_gate_error <= 1'b1;
      else if (fifo_empty) fifo_gate_error <= 1'b0;
      // counter saturates at 31 rather than wrapping
      if (!fifo_gate_error) gate_error_elapsed <= SIS_ELAPSED_RESET;
      else if (sample_tick && gate_error_elapsed != 5'h1f)
        gate_error_elapsed <= gate_error_elapsed + 5'h01;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign fifo_trigger_enable = {fifo_trigger_select[SIS_TRIGGER_ON_TRANSIENT],
                                fifo_trigger_select[SIS_TRIG_ORIENT],
                                fifo_trigger_select[SIS_TRIG_TAP],
                                fifo_trigger_select[SIS_TRIG_FALL]};
  assign system_mode            = mode;
  assign interrupt_source_flags = src_flags;

endmodule

// *** dv/sis_top_properties.sv ***
// checker: port-level properties of the status/interrupt block
`timescale 1ns/1ps
module sis_chk
  import sis_pkg::*;
#(
  parameter logic [7:0] PART_ID     = 8'h5c, // arbitrary neutral value
  parameter int         LIMIT_WIDTH = 8
) (
  input wire logic         mclk,
  input wire logic         rstn,
  input wire logic         clk_en,
  input wire logic [7:0]   reg_addr,
  input wire logic         reg_wr,
  input wire logic [7:0]   reg_wdata,
  input wire logic         reg_rd,
  input wire logic         reg_rd_done,
  input wire logic [7:0]   reg_rdata,
  input wire sis_enables_t int_enable,
  input wire sis_events_t  events,
  input wire logic [3:0]   fifo_trigger_enable,
  input wire sis_mode_t    system_mode,
  input wire logic [7:0]   interrupt_source_flags
);
  // ==========
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // done refers to the last captured read, not to the live address
  logic [7:0] last_rd;
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) last_rd <= 8'h00;
    else if (reg_rd && clk_en) last_rd <= reg_addr;
  wire done_trans = reg_rd_done && last_rd == SIS_ADDR_TRANSIENT_SOURCE_REGISTER;
  wire done_tap   = reg_rd_done && last_rd == SIS_ADDR_TAP_SRC;
  wire done_xyz   = reg_rd_done && last_rd >= SIS_ADDR_XYZ_FIRST && last_rd <= SIS_ADDR_XYZ_LAST;
  wire trans_lvl  = events.transient_active && int_enable.transient;
  wire tap_lvl    = events.tap_active && int_enable.tap;
  wire trig_wr    = clk_en && reg_wr && reg_addr == SIS_ADDR_TRIG_SEL;
  sequence s_id_read;
    clk_en && reg_rd && reg_addr == SIS_ADDR_IDENTITY;
  endsequence
  sequence s_tap_rise;
    clk_en && $rose(tap_lvl);
  endsequence
  a_trig_write: assert property (trig_wr |=> fifo_trigger_enable == $past(reg_wdata[5:2]))
    else $error("trigger select write not applied");
  a_trig_hold: assert property (!trig_wr |=> $stable(fifo_trigger_enable))
    else $error("trigger select changed without a write");
  a_mode_legal: assert property (system_mode != 2'h3)
    else $error("system mode holds the unused code");
  a_spare_zero: assert property (interrupt_source_flags[1] == 1'b0)
    else $error("unused source bit set");
  a_tap_set: assert property (s_tap_rise |-> ##[1:2] interrupt_source_flags[SIS_SRC_TAP])
    else $error("tap flag missed a rising event");
  a_tap_sticky: assert property (interrupt_source_flags[SIS_SRC_TAP] && !done_tap
    |=> interrupt_source_flags[SIS_SRC_TAP]) else $error("tap flag lost without its read");
  a_drdy_keep: assert property (interrupt_source_flags[SIS_NEW_SAMPLE_EVENT_FLAG] && !done_xyz
    |=> interrupt_source_flags[SIS_NEW_SAMPLE_EVENT_FLAG]) else $error("new sample flag lost");
  a_trans_clear: assert property (done_trans && !(trans_lvl && !$past(trans_lvl))
    |=> !interrupt_source_flags[SIS_TRANSIENT_EVENT_FLAG]) else $error("transient flag not cleared");
  a_ident_read: assert property (s_id_read |=> reg_rdata == PART_ID)
    else $error("identity read wrong");
endmodule
bind sis_top sis_chk #(.PART_ID(PART_ID), .LIMIT_WIDTH(LIMIT_WIDTH)) u_chk (
  .mclk(mclk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rd_done(reg_rd_done), .reg_rdata(reg_rdata),
  .int_enable(int_enable), .events(events), .fifo_trigger_enable(fifo_trigger_enable),
  .system_mode(system_mode), .interrupt_source_flags(interrupt_source_flags));

// *** dv/sis_host.sv ***
// host model: single-byte register reads and writes
`timescale 1ns/1ps
module sis_host (
  input  wire logic [7:0] reg_rdata,
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            reg_rd_done
);
  // ==========
  // bus tasks; a released bus shows the inverse, never the last value
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_rd_done = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // done only after the byte is in hand, so no flag slips away
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    reg_rd_done = 1'b1;
    @(posedge mclk);
    #1 reg_rd_done = 1'b0;
  endtask
endmodule

// *** dv/sis_top_tb_top.sv ***
// testbench: random and corner-case checks of the status/interrupt block
`timescale 1ns/1ps
module sis_top_tb_top;
  import sis_pkg::*;
  // ==========
  // stimulus and wiring
  localparam logic [7:0] ID = 8'h5c; // arbitrary part code
  localparam int EVB [7] = '{6, 5, 4, 3, 2, 1, 0};
  localparam int ENB [7] = '{5, 4, 3, 2, 1, 0, 0};
  localparam int FLB [7] = '{6, 5, 4, 3, 2, 0, 0};
  localparam logic [7:0] CLR [5] = '{8'h00, 8'h1e, 8'h10, 8'h22, 8'h16};
  logic mclk = 1'b0, rstn = 1'b0, tick = 1'b0, act = 1'b0, slp = 1'b0, gerr = 1'b0;
  logic ce = 1'b1;
  logic [7:0] lim = 8'h04, r, d, c, addr, wdata, rdata, flags;
  logic [5:0] cnt = 6'h00, wm = 6'h00;
  logic wr, rd, rdone;
  logic [3:0] trig;
  sis_mode_t mode;
  sis_enables_t en = '0, wsel = '0;
  sis_events_t ev = '0;
  int num_errors = 0, checks_done = 0, seed = 78;
  always #4 mclk = ~mclk;
  sis_host h (.mclk(mclk), .reg_rdata(rdata), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rd_done(rdone));
  sis_top #(.PART_ID(ID)) DUT (.mclk(mclk), .rstn(rstn), .clk_en(ce), .reg_addr(addr),
    .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd), .reg_rd_done(rdone), .reg_rdata(rdata),
    .sample_tick(tick), .active_req(act), .sleep_en(slp), .sleep_inactivity_limit(lim),
    .int_enable(en), .wake_select(wsel), .events(ev), .fifo_sample_count(cnt),
    .fifo_watermark_level(wm), .gate_error_detect(gerr), .fifo_trigger_enable(trig),
    .system_mode(mode), .interrupt_source_flags(flags));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic pulse;
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(1);
  endtask
  function automatic logic [7:0] trig_exp(input logic [7:0] v);
    return v & SIS_TRIG_MASK;
  endfunction
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // run is about two hundred cycles; the limit leaves wide margin
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
  initial begin
    cyc(4);
    rstn = 1'b1;
    chk("reset", {flags[7:2], mode}, 8'h00);
    chk("trig_rst", trig, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = i == 0 ? 8'hff : 8'($random(seed));
      h.wr(SIS_ADDR_TRIG_SEL, d);
      h.wr(SIS_ADDR_IDENTITY, ~d);
      h.rd(SIS_ADDR_TRIG_SEL, r);
      chk("trig_rd", r, trig_exp(d));
      chk("trig_out", trig, trig_exp(d) >> 2);
      h.rd(SIS_ADDR_IDENTITY, r);
      chk("identity", r, ID);
    end
    // a write while the clock enable is low must not land
    ce = 1'b0;
    h.wr(SIS_ADDR_TRIG_SEL, ~d);
    ce = 1'b1;
    chk("frozen", trig, trig_exp(d) >> 2);
    for (int j = 0; j < 7; j++) begin
      ev = '0;
      en = '0;
      ev[EVB[j]] = 1'b1;
      cyc(3);
      chk("masked", flags, 8'h00);
      ev = '0;
      en[ENB[j]] = 1'b1;
      cyc(1);
      ev[EVB[j]] = 1'b1;
      cyc(3);
      chk("raised", flags, 8'h01 << FLB[j]);
      h.rd(j == 0 ? SIS_ADDR_SYS_MODE : SIS_ADDR_FIFO_STATUS, r);
      chk("kept", flags, 8'h01 << FLB[j]);
      c = j > 4 ? 8'h01 + 8'($unsigned($random(seed)) % 6) : CLR[j];
      h.rd(c, r);
      cyc(2);
      chk("cleared", flags, 8'h00);
    end
    ev = '0;
    en = '0;
    en.fifo = 1'b1;
    wm = 6'($unsigned($random(seed)) % 31 + 1);
    cnt = wm - 6'h01;
    cyc(3);
    cnt = wm;
    cyc(3);
    chk("watermark", flags, 8'h40);
    h.rd(SIS_ADDR_FIFO_STATUS, r);
    cyc(1);
    chk("wm_clear", flags, 8'h00);
    en = '0;
    act = 1'b1;
    cyc(3);
    chk("wake", mode, SIS_MODE_WAKE);
    gerr = 1'b1;
    cyc(1);
    gerr = 1'b0;
    repeat (3) pulse;
    h.rd(SIS_ADDR_SYS_MODE, r);
    chk("gate", r, 8'h8d);
    cnt = 6'h00;
    cyc(2);
    h.rd(SIS_ADDR_SYS_MODE, r);
    chk("gate_clr", r, 8'h01);
    lim = 8'($unsigned($random(seed)) % 4 + 2);
    slp = 1'b1;
    act = 1'b0;
    cyc(2);
    act = 1'b1;
    cyc(3);
    h.rd(SIS_ADDR_SYS_MODE, r);
    repeat (lim) pulse;
    chk("awake", mode, SIS_MODE_WAKE);
    pulse;
    cyc(2);
    chk("asleep", {flags[7:2], mode}, 8'h82);
    h.rd(SIS_ADDR_SYS_MODE, r);
    cyc(1);
    chk("aslp_clr", {r[1:0], flags[7:2]}, 8'h80);
    wsel.tap = 1'b1;
    en.tap = 1'b1;
    ev.tap_active = 1'b1;
    cyc(3);
    chk("woken", {flags[7:2], mode}, 8'h89);
    stop_test;
  end
endmodule
